// file: pkg/icack_defs.svh
// constants for the interrupt cascade and acknowledge logic
`ifndef ICACK_DEFS_SVH
`define ICACK_DEFS_SVH
`define ICACK_CFG_MODE_SLAVE 1'b0
`define ICACK_CFG_MODE_DAISY 1'b1
`define ICACK_CFG_RESET_ID 2'h0
`define ICACK_VEC_RESET 8'h00
`define ICACK_SYNC_STAGES 3
`endif

// file: pkg/icack_pkg.sv
// types for the interrupt cascade and acknowledge logic
package icack_pkg;
  typedef enum logic [1:0] {
    ICACK_ST_IDLE,
    ICACK_ST_FIRST,
    ICACK_ST_GAP,
    ICACK_ST_DRIVE
  } icack_state_t;
endpackage

// file: hw/icack_sync.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none
module icack_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, out_q;
  logic [WIDTH-1:0] s1_d, s2_d, s3_d, out_d;
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
    s3_d = s2_q;
    out_d = out_q;
    for (int i = 0; i < WIDTH; i++) begin
      // only stages two and three are compared; stage one may be metastable
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      out_q <= out_d;
    end
  end
  assign dout = out_q;
endmodule
`default_nettype wire

// file: hw/icack_top.sv
// interrupt cascade and acknowledge logic: slave-id and daisy-chain schemes
`timescale 1ns/1ps
`default_nettype none
`include "icack_defs.svh"
module icack_top #(
  parameter int VEC_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_mode_daisy,
  input wire logic [1:0] cfg_slave_id,
  input wire logic cfg_vector_en,
  input wire logic [VEC_W-1:0] cfg_vector,
  input wire logic bus_data_strobe_type,
  input wire logic irq_pending,
  input wire logic irq_acknowledge_strobe_n,
  input wire logic data_strobe_n,
  input wire logic chain_enable_in,
  input wire logic slave_addr_lo,
  output logic chain_enable_out,
  output logic irq_n,
  output logic [VEC_W-1:0] data_out,
  output logic data_oe,
  output logic ack_served
);
  logic [3:0] pins_raw, pins_s;
  logic ack_s, ds_s, ie_in_s, ie_lo_s;
  assign pins_raw = {~irq_acknowledge_strobe_n, ~data_strobe_n, chain_enable_in, slave_addr_lo};
  icack_sync #(.WIDTH(4)) u_sync (
    .clk(clk),
    .rst(rst),
    .din(pins_raw),
    .dout(pins_s)
  );
  assign ack_s = pins_s[3];
  assign ds_s = pins_s[2];
  assign ie_in_s = pins_s[1];
  assign ie_lo_s = pins_s[0];

  icack_pkg::icack_state_t st_q, st_d;
  logic ack_prev_q, ack_prev_d;
  logic sel_q, sel_d;
  logic ieo_q, ieo_d;
  logic irq_q, irq_d;
  logic [VEC_W-1:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic served_q, served_d;
  logic ack_rise, ack_fall, selected;

  always_comb begin
    ack_rise = ack_s & ~ack_prev_q;
    ack_fall = ~ack_s & ack_prev_q;
    // in slave mode chain_enable_in and slave_addr_lo carry the two id lines
    if (cfg_mode_daisy == `ICACK_CFG_MODE_DAISY) begin
      selected = ie_in_s & irq_pending;
    end else begin
      selected = irq_pending && ({ie_in_s, ie_lo_s} == cfg_slave_id);
    end
  end

  always_comb begin
    st_d = st_q;
    ack_prev_d = ack_s;
    sel_d = sel_q;
    oe_d = oe_q;
    dout_d = dout_q;
    served_d = 1'b0;
    unique case (st_q)
      icack_pkg::ICACK_ST_IDLE: begin
        oe_d = 1'b0;
        if (ack_rise) begin
          if (bus_data_strobe_type) begin
            st_d = icack_pkg::ICACK_ST_GAP;
          end else begin
            st_d = icack_pkg::ICACK_ST_FIRST;
          end
        end
      end
      icack_pkg::ICACK_ST_FIRST: begin
        // first strobe is only waited out; selection is taken on the second strobe, no data driven
        if (ack_fall) begin
          st_d = icack_pkg::ICACK_ST_GAP;
        end
      end
      icack_pkg::ICACK_ST_GAP: begin
        if (bus_data_strobe_type) begin
          // chain must have settled when data strobe falls
          if (ds_s) begin
            sel_d = selected;
            st_d = icack_pkg::ICACK_ST_DRIVE;
          end else if (!ack_s) begin
            st_d = icack_pkg::ICACK_ST_IDLE;
          end
        end else if (ack_rise) begin
          sel_d = selected;
          st_d = icack_pkg::ICACK_ST_DRIVE;
        end
      end
      icack_pkg::ICACK_ST_DRIVE: begin
        oe_d = sel_q & cfg_vector_en;
        dout_d = sel_q ? cfg_vector : VEC_W'(`ICACK_VEC_RESET);
        if (!ack_s) begin
          served_d = sel_q;
          oe_d = 1'b0;
          sel_d = 1'b0;
          st_d = icack_pkg::ICACK_ST_IDLE;
        end
      end
    endcase
  end

  // chain and poll outputs run on their own, apart from the acknowledge walk
  always_comb begin
    irq_d = ~irq_pending; // pending level stays visible for polling
    // pending blocks the chain; registered behind the pin synchroniser, so each device adds five cycles of delay
    ieo_d = (cfg_mode_daisy == `ICACK_CFG_MODE_DAISY) ? (ie_in_s & ~irq_pending) : 1'b0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ieo_q <= 1'b0;
      irq_q <= 1'b1;
    end else begin
      ieo_q <= ieo_d;
      irq_q <= irq_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= icack_pkg::ICACK_ST_IDLE;
      ack_prev_q <= 1'b0;
      sel_q <= 1'b0;
      dout_q <= VEC_W'(`ICACK_VEC_RESET);
      oe_q <= 1'b0;
      served_q <= 1'b0;
    end else begin
      st_q <= st_d;
      ack_prev_q <= ack_prev_d;
      sel_q <= sel_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      served_q <= served_d;
    end
  end

  assign chain_enable_out = ieo_q;
  assign irq_n = irq_q;
  assign data_out = dout_q;
  assign data_oe = oe_q;
  assign ack_served = served_q;
endmodule
`default_nettype wire

// file: tb/icack_properties.sv
// port checks on the cascade and acknowledge logic
`timescale 1ns/1ps
`default_nettype none
module icack_properties (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfg_mode_daisy,
  input wire logic irq_pending,
  input wire logic chain_enable_in,
  input wire logic irq_acknowledge_strobe_n,
  input wire logic chain_enable_out,
  input wire logic data_oe,
  input wire logic ack_served
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_chain_pass: assert property ((cfg_mode_daisy && chain_enable_in && !irq_pending)[*8] |-> chain_enable_out)
    else $error("chain out low");
  a_chain_hold: assert property (irq_pending[*8] |-> !chain_enable_out)
    else $error("chain out high");
  a_chain_mode: assert property (!cfg_mode_daisy[*8] |-> !chain_enable_out)
    else $error("chain out in slave mode");
  a_chain_sel: assert property ($rose(data_oe) && cfg_mode_daisy |-> chain_enable_in)
    else $error("claimed without chain");
  a_ack_drive: assert property ($rose(data_oe) |-> !irq_acknowledge_strobe_n)
    else $error("drive outside ack");
  a_pend_only: assert property ($rose(data_oe) |-> irq_pending)
    else $error("drive without request");
  a_served_one: assert property (ack_served |=> !ack_served) else $error("served pulse");
  a_served_end: assert property (ack_served |-> $past(data_oe)) else $error("served undriven");
endmodule
bind icack_top icack_properties icack_properties_inst (.*);
`default_nettype wire

// file: tb/icack_host.sv
// host model: acknowledge strobes for both bus types
`timescale 1ns/1ps
`default_nettype none
module icack_host (
  input wire logic clk,
  output logic irq_acknowledge_strobe_n,
  output logic data_strobe_n
);
  // glue logic answers as a 16-bit port on acknowledge cycles
  logic [1:0] port_size_acknowledge = 2'h1;
  initial {irq_acknowledge_strobe_n, data_strobe_n} = 2'b11;
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ack(input logic ds);
    irq_acknowledge_strobe_n = 0;
    gap(6);
    if (ds) data_strobe_n = 0;
    else irq_acknowledge_strobe_n = 1;
    gap(6);
    irq_acknowledge_strobe_n = 0;
    gap(8);
    {irq_acknowledge_strobe_n, data_strobe_n} = 2'b11;
    gap(8);
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// bench: daisy and slave acknowledges on both bus types
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH %s %h %h", n, e, g); end end
module tb_top;
  logic clk = 0, rst = 1, cfg_mode_daisy = 0, cfg_vector_en = 1, bus_data_strobe_type = 0, irq_pending = 0;
  logic chain_enable_in = 0, slave_addr_lo = 0, chain_enable_out, irq_n, data_oe, ack_served, seen = 0, served = 0;
  logic [1:0] cfg_slave_id = 2'h2;
  logic [7:0] cfg_vector = 8'h5a, data_out, got;
  wire logic irq_acknowledge_strobe_n, data_strobe_n;
  int n_mismatch = 0, samples_checked = 0;
  always #50 clk = ~clk;
  icack_host icack_host_inst (.*);
  icack_top icack_top_inst (.*);
  always @(posedge clk) if (data_oe === 1'b1) {seen, got} <= {1'b1, data_out};
  always @(posedge clk) if (ack_served === 1'b1) served <= 1'b1;
  // c: mode, bus type, pending, chain in
  task automatic run(input logic [3:0] c, input logic e);
    {cfg_mode_daisy, bus_data_strobe_type, irq_pending, chain_enable_in} = c;
    seen = 0;
    served = 0;
    icack_host_inst.ack(c[2]);
    `CHK("data_oe", e, seen)
    `CHK("ack_served", e, served)
  endtask
  task automatic t_chain;
    {cfg_mode_daisy, chain_enable_in} = 2'b11;
    icack_host_inst.gap(8);
    `CHK("chain_out", 1'b1, chain_enable_out)
    `CHK("port_size", 2'h1, icack_host_inst.port_size_acknowledge)
    irq_pending = 1;
    icack_host_inst.gap(8);
    `CHK("chain_out", 1'b0, chain_enable_out)
    `CHK("irq_n", 1'b0, irq_n)
  endtask
  task automatic t_daisy;
    run(4'b1011, 1);
    `CHK("vector", cfg_vector, got)
    run(4'b1111, 1);
    run(4'b1110, 0);
  endtask
  task automatic t_slave;
    run(4'b0011, 1);
    slave_addr_lo = 1;
    run(4'b0011, 0);
    slave_addr_lo = 0;
    run(4'b0101, 0);
  endtask
  task automatic test_done;
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    icack_host_inst.gap(12);
    rst = 0;
    t_chain;
    t_daisy;
    t_slave;
    test_done;
  end
  initial begin
    #100000;
    n_mismatch++;
    test_done;
  end
endmodule
`default_nettype wire
